// File: src/asc_params.svh
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH

// Register addresses
`define ASC_ADDR_STATUS 4'h2
`define ASC_ADDR_CMD 4'h3
`define ASC_ADDR_INSEL 4'h4

// Status field positions
`define ASC_ST_LINK_ERR 4
`define ASC_ST_MAP_ERR 3
`define ASC_ST_FAULT 2
`define ASC_ST_SAT 1
`define ASC_ST_NEW 0

// Command register fields
`define ASC_CMD_START 1
`define ASC_CMD_STOP 0
`define ASC_RESET_KEY 6'h16

// Reset values
`define ASC_INSEL_RST 2'h0
`define ASC_BYTE_ZERO 8'h00

// Link frame layout
`define ASC_FRAME_BITS 16
`define ASC_FRAME_RW 15

`endif

// File: src/asc_pkg.sv
package asc_pkg;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    ASC_IDLE,
    ASC_RUN,
    ASC_STOPPING
  } asc_state_t;

  // Trigger mode codes
  typedef enum logic [1:0] {
    ASC_TRIG_STARTSTOP = 2'h0,
    ASC_TRIG_ONESHOT = 2'h1,
    ASC_TRIG_SYNC = 2'h2,
    ASC_TRIG_RSVD = 2'h3
  } asc_trig_t;

  // Input selector codes
  typedef enum logic [1:0] {
    ASC_SEL_NORMAL = 2'h0,
    ASC_SEL_INVERT = 2'h1,
    ASC_SEL_MIDSHORT = 2'h2,
    ASC_SEL_COMMON = 2'h3
  } asc_sel_t;

endpackage

// File: src/asc_regs.sv
`timescale 1ns/10ps
`include "asc_params.svh"

module asc_regs
  import asc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Serial link, own clock domain
  input wire logic link_sclk,
  input wire logic link_cs_b,
  input wire logic link_sdi,
  output logic link_sdo,
  output logic link_sdo_oe_b,
  // Configuration bits held elsewhere
  input wire logic [1:0] trig_mode,
  input wire logic link_crc_en,
  input wire logic map_crc_en,
  input wire logic link_crc_fail,
  input wire logic [7:0] map_crc_written,
  input wire logic [7:0] map_crc_calc,
  // Converter core
  input wire logic internal_fault,
  input wire logic mod_saturated,
  input wire logic conv_done,
  input wire logic data_read,
  output logic conv_active,
  output logic conv_restart,
  output logic soft_reset,
  output logic [1:0] input_selector,
  output logic data_ready_b
);

  // Link domain state
  logic [3:0] bit_cnt_r;
  logic [14:0] rx_r;
  logic [15:0] frame_r;
  logic frame_tgl_r;
  logic link_rst_b;

  // System domain state
  logic [2:0] tgl_sync_r;
  logic [1:0] insel_r;
  logic link_err_r;
  logic map_err_r;
  logic fault_r;
  logic sat_r;
  logic sat_seen_r;
  logic new_data_r;
  logic [7:0] rdata_r;
  logic restart_r;
  logic srst_r;
  asc_state_t state_r;
  asc_state_t state_nxt;

  // Set has priority over clear on the link error, map error and fault flags
  function automatic logic flag_nxt(input logic cur, input logic set, input logic clr);
    flag_nxt = set | (cur & ~clr);
  endfunction

  // Address match used by the write and read decode
  function automatic logic addr_is(input logic [3:0] a, input logic [3:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  // Link logic held in reset while the frame is deselected
  assign link_rst_b = rst_b & ~link_cs_b;

  // Shift in frame bits, publish the complete word with a toggle
  always_ff @(posedge link_sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      bit_cnt_r <= 4'h0;
      rx_r <= 15'h0000;
    end else begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      rx_r <= {rx_r[13:0], link_sdi};
    end
  end

  // Word and toggle survive deselect, so only device reset clears them
  always_ff @(posedge link_sclk or negedge rst_b) begin
    if (!rst_b) begin
      frame_r <= 16'h0000;
      frame_tgl_r <= 1'b0;
    end else if (!link_cs_b && bit_cnt_r == 4'hf) begin
      frame_r <= {rx_r, link_sdi};
      frame_tgl_r <= ~frame_tgl_r;
    end
  end

  // Previous read answer goes out in the first byte, MSB first
  assign link_sdo = (!bit_cnt_r[3]) ? rdata_r[3'h7 - bit_cnt_r[2:0]] : 1'b0;
  assign link_sdo_oe_b = link_cs_b;

  // Frame decode in the system domain
  logic frame_evt;
  logic is_read;
  logic is_write;
  logic [3:0] f_addr;
  logic [7:0] f_data;
  logic wr_allowed;
  logic wr_status;
  logic wr_cmd;
  logic wr_insel;
  logic cmd_start;
  logic cmd_stop;
  logic cmd_both;
  logic key_hit;
  logic mode_cmds;
  logic start_eff;
  logic stop_eff;
  logic clr_link;
  logic clr_map;
  logic map_mismatch;
  logic done_eff;
  logic [7:0] status_rd;
  logic [7:0] read_val;

  assign frame_evt = tgl_sync_r[2] ^ tgl_sync_r[1];
  assign is_read = frame_evt & frame_r[`ASC_FRAME_RW];
  assign is_write = frame_evt & ~frame_r[`ASC_FRAME_RW];
  assign f_addr = frame_r[11:8];
  assign f_data = frame_r[7:0];

  // Writes blocked while link error stands, except to status
  assign wr_allowed = ~link_err_r | addr_is(f_addr, `ASC_ADDR_STATUS);
  assign wr_status = is_write & addr_is(f_addr, `ASC_ADDR_STATUS);
  assign wr_cmd = is_write & wr_allowed & addr_is(f_addr, `ASC_ADDR_CMD);
  assign wr_insel = is_write & wr_allowed & addr_is(f_addr, `ASC_ADDR_INSEL);

  // Command decode
  assign cmd_start = f_data[`ASC_CMD_START];
  assign cmd_stop = f_data[`ASC_CMD_STOP];
  assign cmd_both = cmd_start & cmd_stop;
  assign key_hit = wr_cmd & (f_data[7:2] == `ASC_RESET_KEY) & ~cmd_start & ~cmd_stop;
  assign mode_cmds = (trig_mode == ASC_TRIG_STARTSTOP) | (trig_mode == ASC_TRIG_ONESHOT);
  assign start_eff = wr_cmd & ~key_hit & mode_cmds & cmd_start & ~cmd_both;
  assign stop_eff = wr_cmd & ~key_hit & mode_cmds & cmd_stop & ~cmd_both;

  // Clear requests on status flags; zero bits leave flags alone, except that the map flag clears while map CRC is off
  assign clr_link = wr_status & f_data[`ASC_ST_LINK_ERR];
  assign clr_map = (wr_status & f_data[`ASC_ST_MAP_ERR]) | ~map_crc_en;
  assign map_mismatch = map_crc_en & (map_crc_written != map_crc_calc);
  assign done_eff = conv_done & (state_r != ASC_IDLE);

  // Status image; read-only fields have no write path
  assign status_rd = {3'h0, link_err_r, map_err_r, fault_r, sat_r, new_data_r};

  // Read mux; command register always reads zero
  assign read_val = addr_is(f_addr, `ASC_ADDR_STATUS) ? status_rd :
                    addr_is(f_addr, `ASC_ADDR_INSEL) ? {6'h00, insel_r} :
                    `ASC_BYTE_ZERO;

  // Conversion sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ASC_IDLE: begin
        if (start_eff) begin
          state_nxt = ASC_RUN;
        end
      end
      ASC_RUN: begin
        if (start_eff) begin
          state_nxt = ASC_RUN;
        end else if (done_eff && trig_mode == ASC_TRIG_ONESHOT) begin
          state_nxt = ASC_IDLE;
        end else if (stop_eff && done_eff) begin
          state_nxt = ASC_IDLE;
        end else if (stop_eff) begin
          state_nxt = ASC_STOPPING;
        end
      end
      ASC_STOPPING: begin
        if (start_eff) begin
          state_nxt = ASC_RUN;
        end else if (done_eff) begin
          state_nxt = ASC_IDLE;
        end
      end
      default: begin
        state_nxt = ASC_IDLE;
      end
    endcase
  end

  // Two-flop synchroniser plus edge stage for the frame toggle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_sync_r <= 3'h0;
    end else if (ce) begin
      tgl_sync_r <= {tgl_sync_r[1:0], frame_tgl_r};
    end
  end

  // Next values of the system-domain registers
  logic link_set;
  logic map_set;
  logic fault_set;
  logic link_err_nxt;
  logic map_err_nxt;
  logic fault_nxt;
  logic sat_nxt;
  logic sat_seen_nxt;
  logic new_data_nxt;
  logic [1:0] insel_nxt;
  logic [7:0] rdata_nxt;
  logic restart_nxt;
  logic srst_nxt;
  asc_state_t state_go;

  // Command pulses; soft reset blocks a restart in the same cycle
  assign restart_nxt = start_eff & ~srst_r;
  assign srst_nxt = key_hit;
  assign state_go = srst_r ? ASC_IDLE : state_nxt;

  // Flag set events
  assign link_set = link_crc_en & link_crc_fail;
  assign map_set = map_mismatch;
  assign fault_set = internal_fault;

  // Flag next values; set wins over clear
  assign link_err_nxt = flag_nxt(link_err_r, link_set, clr_link | srst_r);
  assign map_err_nxt = flag_nxt(map_err_r, map_set, clr_map | srst_r);
  assign fault_nxt = flag_nxt(fault_r, fault_set, srst_r);

  // Saturation accumulated over a conversion, published at its end
  always_comb begin
    sat_nxt = sat_r;
    sat_seen_nxt = sat_seen_r | mod_saturated;
    if (srst_r) begin
      sat_nxt = 1'b0;
      sat_seen_nxt = 1'b0;
    end else if (done_eff) begin
      sat_nxt = sat_seen_r | mod_saturated;
      sat_seen_nxt = 1'b0;
    end else if (start_eff) begin
      sat_seen_nxt = mod_saturated;
    end
  end

  // New-data flag; one-shot holds it until the next start
  always_comb begin
    new_data_nxt = new_data_r & ~data_read;
    if (srst_r) begin
      new_data_nxt = 1'b0;
    end else if (done_eff) begin
      new_data_nxt = 1'b1;
    end else if (trig_mode == ASC_TRIG_ONESHOT) begin
      new_data_nxt = new_data_r & ~start_eff;
    end
  end

  // Selector write and read answer capture
  always_comb begin
    insel_nxt = insel_r;
    rdata_nxt = rdata_r;
    if (srst_r) begin
      insel_nxt = `ASC_INSEL_RST;
    end else if (wr_insel) begin
      insel_nxt = f_data[1:0];
    end
    if (is_read) begin
      rdata_nxt = read_val;
    end else if (is_write) begin
      rdata_nxt = `ASC_BYTE_ZERO;
    end
  end

  // Sequencer state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ASC_IDLE;
    end else if (ce) begin
      state_r <= state_go;
    end
  end

  // Restart pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      restart_r <= 1'b0;
    end else if (ce) begin
      restart_r <= restart_nxt;
    end
  end

  // Soft reset pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      srst_r <= 1'b0;
    end else if (ce) begin
      srst_r <= srst_nxt;
    end
  end

  // Link error flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link_err_r <= 1'b0;
    end else if (ce) begin
      link_err_r <= link_err_nxt;
    end
  end

  // Map error flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      map_err_r <= 1'b0;
    end else if (ce) begin
      map_err_r <= map_err_nxt;
    end
  end

  // Internal fault flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_r <= 1'b0;
    end else if (ce) begin
      fault_r <= fault_nxt;
    end
  end

  // Published saturation flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sat_r <= 1'b0;
    end else if (ce) begin
      sat_r <= sat_nxt;
    end
  end

  // Saturation seen in the running conversion
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sat_seen_r <= 1'b0;
    end else if (ce) begin
      sat_seen_r <= sat_seen_nxt;
    end
  end

  // New-data flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      new_data_r <= 1'b0;
    end else if (ce) begin
      new_data_r <= new_data_nxt;
    end
  end

  // Input selector
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      insel_r <= `ASC_INSEL_RST;
    end else if (ce) begin
      insel_r <= insel_nxt;
    end
  end

  // Read answer, held for the next frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= `ASC_BYTE_ZERO;
    end else if (ce) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs to the converter core
  assign conv_active = (state_r != ASC_IDLE);
  assign conv_restart = restart_r;
  assign soft_reset = srst_r;
  assign input_selector = insel_r;
  assign data_ready_b = ~new_data_r;

endmodule // asc_regs

// File: tb/asc_regs_sva.sv
`timescale 1ns/10ps
module asc_regs_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] trig_mode,
  input wire logic conv_done,
  input wire logic conv_active,
  input wire logic conv_restart,
  input wire logic soft_reset,
  input wire logic [1:0] input_selector,
  input wire logic data_ready_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // State seen right after a soft reset
  sequence cleared_s;
    input_selector == 2'h0 && !conv_active && data_ready_b;
  endsequence
  // Conversion end or soft reset one cycle back
  sequence ended_s;
    $past(conv_done) || $past(soft_reset);
  endsequence
  restart_runs_a: assert property (conv_restart |=> conv_active)
    else $error("restart left sequencer idle");
  restart_pulse_a: assert property (conv_restart |=> !conv_restart)
    else $error("restart pulse too long");
  soft_pulse_a: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset pulse too long");
  soft_clear_a: assert property (soft_reset |=> cleared_s)
    else $error("soft reset left state");
  soft_excl_a: assert property (!(soft_reset && conv_restart))
    else $error("soft reset with restart");
  sync_ignore_a: assert property (conv_restart |-> !$past(trig_mode[1]))
    else $error("restart in sync mode");
  stop_done_a: assert property ($fell(conv_active) |-> ended_s)
    else $error("halt before conversion end");
  new_done_a: assert property ($fell(data_ready_b) |-> $past(conv_done))
    else $error("new data without conversion");
  oneshot_hold_a: assert property ($rose(data_ready_b) && trig_mode == 2'h1
    |-> conv_restart || $past(conv_restart) || $past(soft_reset))
    else $error("one-shot data flag dropped");
endmodule // asc_regs_chk

bind asc_regs asc_regs_chk asc_regs_chk_inst (.clk(clk), .rst_b(rst_b),
  .trig_mode(trig_mode), .conv_done(conv_done), .conv_active(conv_active),
  .conv_restart(conv_restart), .soft_reset(soft_reset),
  .input_selector(input_selector), .data_ready_b(data_ready_b));

// File: tb/asc_host.sv
`timescale 1ns/10ps
module asc_host (
  output logic link_sclk,
  output logic link_cs_b,
  output logic link_sdi,
  input wire logic link_sdo
);
  // Idle link: clock still, deselected
  initial begin
    link_sclk = 1'b0;
    link_cs_b = 1'b1;
    link_sdi = 1'b0;
  end
  // One frame, MSB first; first byte of reply kept
  task automatic xfer(input logic [15:0] w, output logic [7:0] r);
    link_cs_b = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      link_sdi = w[i];
      #3;
      if (i > 7) r[i-8] = link_sdo;
      link_sclk = 1'b1;
      #3 link_sclk = 1'b0;
    end
    #3 link_cs_b = 1'b1;
    link_sdi = ~link_sdi; // Released line shows no stale bit
    #300; // Gap so the word lands before the next frame
  endtask
endmodule // asc_host

// File: tb/adc_status_control_regs_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module adc_status_control_regs_test;
  logic clk, rst_b, ce, link_sclk, link_cs_b, link_sdi, link_sdo, link_sdo_oe_b;
  logic [1:0] trig_mode, input_selector;
  logic link_crc_en, map_crc_en, mod_saturated, conv_active, conv_restart;
  logic soft_reset, data_ready_b;
  logic [7:0] map_crc_written, map_crc_calc, r;
  logic [3:0] ev;
  int n_errors, check_count;
  wire conv_done = ev[0];
  wire data_read = ev[1];
  wire link_crc_fail = ev[2];
  wire internal_fault = ev[3];
  asc_regs asc_regs_inst (.clk(clk), .rst_b(rst_b), .ce(ce), .link_sclk(link_sclk),
    .link_cs_b(link_cs_b), .link_sdi(link_sdi), .link_sdo(link_sdo),
    .link_sdo_oe_b(link_sdo_oe_b), .trig_mode(trig_mode), .link_crc_en(link_crc_en),
    .map_crc_en(map_crc_en), .link_crc_fail(link_crc_fail),
    .map_crc_written(map_crc_written), .map_crc_calc(map_crc_calc),
    .internal_fault(internal_fault), .mod_saturated(mod_saturated),
    .conv_done(conv_done), .data_read(data_read), .conv_active(conv_active),
    .conv_restart(conv_restart), .soft_reset(soft_reset),
    .input_selector(input_selector), .data_ready_b(data_ready_b));
  asc_host asc_host_inst (.link_sclk(link_sclk), .link_cs_b(link_cs_b),
    .link_sdi(link_sdi), .link_sdo(link_sdo));
  // Clock
  always #12.5 clk = ~clk;
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One-cycle event pulse
  task automatic pulse(int k);
    @(posedge clk) ev[k] <= 1'b1;
    @(posedge clk) ev[k] <= 1'b0;
    tick(1);
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    asc_host_inst.xfer({4'h0, a, d}, r);
  endtask
  // Read answer comes in the following frame
  task automatic rd(logic [3:0] a);
    asc_host_inst.xfer({4'h8, a, 8'h00}, r);
    asc_host_inst.xfer(16'h8000, r);
  endtask
  task automatic t_sel;
    rd(4'h3);
    `CHK(r, 8'h00)
    for (int i = 0; i < 4; i++) begin
      wr(4'h4, 8'(i));
      `CHK(input_selector, 2'(i))
      rd(4'h4);
      `CHK(r, 8'(i))
    end
    rd(4'ha);
    `CHK(r, 8'h00)
    $display("t_sel done");
  endtask
  task automatic t_run;
    wr(4'h3, 8'h00);
    wr(4'h3, 8'h02);
    `CHK(conv_active, 1'b1)
    pulse(0);
    pulse(0);
    wr(4'h3, 8'h02);
    `CHK(conv_active, 1'b1)
    wr(4'h3, 8'h03);
    wr(4'h3, 8'h01);
    `CHK(conv_active, 1'b1)
    pulse(0);
    tick(1);
    `CHK(conv_active, 1'b0)
    wr(4'h3, 8'h03);
    `CHK(conv_active, 1'b0)
    $display("t_run done");
  endtask
  task automatic t_sync;
    for (int m = 2; m < 4; m++) begin
      @(posedge clk) trig_mode <= 2'(m);
      wr(4'h3, 8'h02);
      `CHK(conv_active, 1'b0)
    end
    wr(4'h4, 8'h02);
    wr(4'h3, 8'h5a);
    `CHK(input_selector, 2'h2)
    $display("t_sync done");
  endtask
  task automatic t_one;
    @(posedge clk) trig_mode <= 2'h1;
    @(posedge clk) mod_saturated <= 1'b1;
    wr(4'h3, 8'h00);
    wr(4'h3, 8'h02);
    pulse(0);
    `CHK(data_ready_b, 1'b0)
    `CHK(conv_active, 1'b0)
    pulse(1);
    rd(4'h2);
    `CHK(r[1:0], 2'h3)
    @(posedge clk) mod_saturated <= 1'b0;
    wr(4'h3, 8'h02);
    `CHK(data_ready_b, 1'b1)
    pulse(0);
    rd(4'h2);
    `CHK(r[1], 1'b0)
    $display("t_one done");
  endtask
  task automatic t_err;
    wr(4'h4, 8'h03);
    pulse(2);
    rd(4'h2);
    `CHK(r[4], 1'b0)
    @(posedge clk) link_crc_en <= 1'b1;
    pulse(2);
    wr(4'h4, 8'h01);
    `CHK(input_selector, 2'h3)
    wr(4'h2, 8'h00);
    rd(4'h2);
    `CHK(r[4], 1'b1)
    wr(4'h2, 8'h10);
    rd(4'h2);
    `CHK(r[4], 1'b0)
    @(posedge clk) map_crc_written <= 8'h5a;
    rd(4'h2);
    `CHK(r[3], 1'b1)
    @(posedge clk) map_crc_written <= 8'h00;
    wr(4'h2, 8'h08);
    rd(4'h2);
    `CHK(r[3], 1'b0)
    @(posedge clk) map_crc_written <= 8'h5a;
    @(posedge clk) map_crc_en <= 1'b0;
    rd(4'h2);
    `CHK(r[3], 1'b0)
    pulse(3);
    wr(4'h2, 8'h04);
    rd(4'h2);
    `CHK(r[2], 1'b1)
    wr(4'h3, 8'h58);
    rd(4'h2);
    `CHK(r[2], 1'b0)
    `CHK(input_selector, 2'h0)
    $display("t_err done");
  endtask
  task end_sim;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog against a hung run
  initial begin
    #2_000_000;
    n_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    {clk, rst_b, trig_mode, link_crc_en, mod_saturated, ev, map_crc_calc} = '0;
    {map_crc_written, n_errors, check_count} = '0;
    ce = 1'b1;
    map_crc_en = 1'b1;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    tick(2);
    `CHK(data_ready_b, 1'b1)
    `CHK(link_sdo_oe_b, 1'b1)
    t_sel();
    t_run();
    t_sync();
    t_one();
    t_err();
    end_sim();
  end
endmodule // adc_status_control_regs_test
